// ### core/prog_write_port.sv
// device side of the parallel programming write port
// What this block does
// - decode type selector into target register
// - ready low while busy, high when free
// - bus direction flag low while bus inputs
// - on falling strobe capture, then drop ready
// - execute, await strobe high, then raise ready
`timescale 1ns/1ns
`default_nettype none
module prog_write_port
  import prog_port_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CMD_STROBE_N,
  input  wire logic [3:0]  TYPE_SELECT,
  input  wire logic [15:0] PROG_DATA_IN,
  output var  logic [15:0] PROG_DATA_OUT,
  output var  logic [15:0] PROG_DATA_OE,
  output var  logic        READY_OUT,
  output var  logic        BUS_DIR_FLAG,
  output var  logic [15:0] COMMAND_REG,
  output var  logic [63:0] ADDRESS_REG,
  output var  logic [15:0] DATA_REG,
  output var  logic        WRITE_DONE
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_EXEC    = 3'b010,
    ST_RELEASE = 3'b100
  } state_t;

  localparam int unsigned CW = $clog2(EXEC_CYCLES + 1);

  function automatic reg_sel_t decode_sel(input logic [3:0] sel);
    reg_sel_t r;
    r = '0;
    case (sel)
      SEL_COMMAND:  r.command  = 1'b1;
      SEL_ADDR_LOW: r.addr_low = 1'b1;
      SEL_ADDR_M1:  r.addr_m1  = 1'b1;
      SEL_ADDR_M2:  r.addr_m2  = 1'b1;
      SEL_ADDR_HI:  r.addr_hi  = 1'b1;
      SEL_DATA:     r.data     = 1'b1;
      default:      r = '0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  state_t        state_q;
  logic          strobe_prev_q;
  logic          strobe_fall;
  logic          cap_valid;
  logic          cap_ready;
  prog_word_t    cap_word;
  logic          fifo_valid;
  logic          fifo_ready;
  logic [$bits(prog_word_t)-1:0] fifo_data;
  prog_word_t    exec_word;
  reg_sel_t      dec;
  logic [CW-1:0] exec_cnt_q;
  logic          exec_end;
  logic          exec_load;
  logic [3:0]    addr_hit;

  // strobe history resets high since the pin is pulled up
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= CMD_STROBE_N;
    end
  end

  assign strobe_fall    = strobe_prev_q && !CMD_STROBE_N;
  assign cap_valid      = (state_q == ST_IDLE) && strobe_fall;
  assign cap_word.sel   = TYPE_SELECT;
  assign cap_word.data  = PROG_DATA_IN;

  prog_word_fifo #(
    .WIDTH ($bits(prog_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (cap_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  assign exec_word  = prog_word_t'(fifo_data);
  // one word executes at a time; the counter stalls the drain side
  assign fifo_ready = (exec_cnt_q == '0);
  assign exec_end   = (exec_cnt_q == CW'(1));
  assign exec_load  = fifo_valid && fifo_ready;

  ////////////////////////////////////////////////////////////////////////
  // execution timer
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      exec_cnt_q <= '0;
    end else if (exec_load) begin
      exec_cnt_q <= CW'(EXEC_CYCLES);
    end else if (exec_cnt_q != '0) begin
      exec_cnt_q <= exec_cnt_q - 1'b1;
    end
  end

  assign dec = decode_sel(exec_word.sel);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      COMMAND_REG <= REG_RESET;
      DATA_REG    <= REG_RESET;
    end else if (exec_load) begin
      if (dec.command) COMMAND_REG <= exec_word.data;
      if (dec.data)    DATA_REG    <= exec_word.data;
    end
  end

  assign addr_hit = {dec.addr_hi, dec.addr_m2, dec.addr_m1, dec.addr_low};

  for (genvar g = 0; g < 4; g++) begin : g_addr
    logic [15:0] part_q;
    // part moves only on its own code
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        part_q <= REG_RESET;
      end else if (exec_load && addr_hit[g]) begin
        part_q <= exec_word.data;
      end
    end
  end

  // one flop set per part keeps a single driver on each slice
  assign ADDRESS_REG = {g_addr[3].part_q, g_addr[2].part_q, g_addr[1].part_q, g_addr[0].part_q};

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WRITE_DONE <= 1'b0;
    end else begin
      WRITE_DONE <= exec_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handshake: ready drops after capture, returns once both the
  // strobe is high and execution has finished
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // a full fifo blocks capture; cannot occur with one word in flight
          if (cap_valid && cap_ready) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (CMD_STROBE_N && !fifo_valid && (exec_cnt_q == '0 || exec_end)) begin
            state_q <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      READY_OUT <= READY_RESET;
    end else if (cap_valid && cap_ready) begin
      READY_OUT <= 1'b0;
    end else if (state_q == ST_RELEASE) begin
      READY_OUT <= 1'b1;
    end
  end

  // bus is input-only for writes
  // limitation: no read path, so the bus never turns around and
  // the enables stay low; a read engine would own these flops
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS_DIR_FLAG  <= DIR_INPUT;
      PROG_DATA_OUT <= REG_RESET;
      PROG_DATA_OE  <= REG_RESET;
    end else begin
      BUS_DIR_FLAG  <= DIR_INPUT;
      PROG_DATA_OUT <= REG_RESET;
      PROG_DATA_OE  <= REG_RESET;
    end
  end

endmodule // prog_write_port
`default_nettype wire

// ### core/prog_port_pkg.sv
// shared constants and carrier types for the parallel programming write port
package prog_port_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W  = 4;

  // type selector codes
  localparam logic [3:0] SEL_COMMAND  = 4'h0;
  localparam logic [3:0] SEL_ADDR_LOW = 4'h1;
  localparam logic [3:0] SEL_ADDR_M1  = 4'h2;
  localparam logic [3:0] SEL_ADDR_M2  = 4'h3;
  localparam logic [3:0] SEL_ADDR_HI  = 4'h4;
  localparam logic [3:0] SEL_DATA     = 4'h5;

  // reset values
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic        READY_RESET = 1'b1;
  localparam logic        DIR_INPUT   = 1'b0;

  // timing: execution time of a captured word, in ns and in cycles
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned EXEC_TIME_NS  = 100;
  localparam int unsigned EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FIFO_DEPTH = 8;

  // one captured transfer
  typedef struct packed {
    logic [3:0]  sel;
    logic [15:0] data;
  } prog_word_t;

  // decoded register targets
  typedef struct packed {
    logic command;
    logic addr_low;
    logic addr_m1;
    logic addr_m2;
    logic addr_hi;
    logic data;
  } reg_sel_t;

endpackage : prog_port_pkg

// ### core/prog_word_fifo.sv
// parameterised valid/ready fifo for captured programming words
`timescale 1ns/1ns
`default_nettype none
module prog_word_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // prog_word_fifo
`default_nettype wire

// ### bench/prog_host.sv
// programmer model that drives write transfers
`timescale 1ns/1ns
`default_nettype none
module prog_host (
  input  wire logic        clk,
  input  wire logic        rdy,
  output var  logic        stb_n,
  output var  logic [3:0]  sel,
  output var  logic [15:0] dat
);
  initial begin
    stb_n = 1'b1;
    sel = 4'hF;
    dat = 16'hFFFF;
  end
  task automatic wr(input logic [3:0] s, input logic [15:0] d, input int slow);
    @(posedge clk);
    sel <= s;
    dat <= d;
    @(posedge clk);
    stb_n <= 1'b0;
    do @(posedge clk); while (rdy !== 1'b0);
    // a released bus shows the inverse, so a late capture cannot pass
    sel <= ~s;
    dat <= ~d;
    repeat (slow) @(posedge clk);
    stb_n <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
endmodule // prog_host
`default_nettype wire

// ### bench/prog_write_port_chk.sv
// pin-level assertions for the write port
`timescale 1ns/1ns
`default_nettype none
module prog_write_port_chk
  import prog_port_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        CMD_STROBE_N,
  input wire logic [3:0]  TYPE_SELECT,
  input wire logic [15:0] PROG_DATA_IN,
  input wire logic [15:0] PROG_DATA_OE,
  input wire logic        READY_OUT,
  input wire logic        BUS_DIR_FLAG,
  input wire logic [15:0] COMMAND_REG,
  input wire logic [63:0] ADDRESS_REG,
  input wire logic [15:0] DATA_REG,
  input wire logic        WRITE_DONE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_take;
    !CMD_STROBE_N && $past(CMD_STROBE_N) && READY_OUT;
  endsequence
  property p_route;
    s_take ##0 (TYPE_SELECT == SEL_DATA) |-> ##2 DATA_REG == $past(PROG_DATA_IN, 2);
  endproperty
  a_route: assert property (p_route) else $error("data word not routed");
  property p_cap;
    s_take |-> ##1 $fell(READY_OUT);
  endproperty
  a_cap: assert property (p_cap) else $error("ready not dropped");
  property p_busy;
    s_take |=> !READY_OUT [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("ready up while busy");
  property p_dir;
    BUS_DIR_FLAG == DIR_INPUT && PROG_DATA_OE == 16'h0000;
  endproperty
  a_dir: assert property (p_dir) else $error("bus not in input mode");
  property p_rise;
    $rose(READY_OUT) |-> $past(CMD_STROBE_N, 2) && $past(CMD_STROBE_N);
  endproperty
  a_rise: assert property (p_rise) else $error("ready rose with strobe low");
  property p_done;
    s_take |-> ##4 WRITE_DONE;
  endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_keep;
    s_take ##0 (TYPE_SELECT > SEL_DATA) |-> ##2 $stable(COMMAND_REG) && $stable(ADDRESS_REG) && $stable(DATA_REG);
  endproperty
  a_keep: assert property (p_keep) else $error("register changed");
endmodule // prog_write_port_chk
bind prog_write_port prog_write_port_chk chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CMD_STROBE_N(CMD_STROBE_N),
  .TYPE_SELECT(TYPE_SELECT), .PROG_DATA_IN(PROG_DATA_IN), .PROG_DATA_OE(PROG_DATA_OE), .READY_OUT(READY_OUT),
  .BUS_DIR_FLAG(BUS_DIR_FLAG), .COMMAND_REG(COMMAND_REG), .ADDRESS_REG(ADDRESS_REG), .DATA_REG(DATA_REG),
  .WRITE_DONE(WRITE_DONE));
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the write port
`timescale 1ns/1ns
`default_nettype none
module tb;
  import prog_port_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        stb_n, rdy, dir, done;
  logic [3:0]  sel;
  logic [15:0] hdat, dout, oe, bus, creg, dreg, ec, ed;
  logic [63:0] areg, ea;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_done = 0;
  prog_word_t  rows [9] = '{'{4'h0, 16'hA5C3}, '{4'h1, 16'h1234}, '{4'h2, 16'hFFFF}, '{4'h3, 16'h0001},
    '{4'h4, 16'h8000}, '{4'h5, 16'h5A5A}, '{4'h6, 16'hDEAD}, '{4'hF, 16'hBEEF}, '{4'h5, 16'h0000}};
  assign bus = (oe & dout) | (~oe & hdat);
  prog_write_port dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CMD_STROBE_N(stb_n), .TYPE_SELECT(sel),
    .PROG_DATA_IN(bus), .PROG_DATA_OUT(dout), .PROG_DATA_OE(oe), .READY_OUT(rdy), .BUS_DIR_FLAG(dir),
    .COMMAND_REG(creg), .ADDRESS_REG(areg), .DATA_REG(dreg), .WRITE_DONE(done));
  prog_host host (.clk(CORE_CLK), .rdy(rdy), .stb_n(stb_n), .sel(sel), .dat(hdat));
  initial forever #25 CORE_CLK = ~CORE_CLK;
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a hang ends in the same report
  always @(posedge CORE_CLK) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    ec = REG_RESET;
    ed = REG_RESET;
    ea = 64'h0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      host.wr(rows[i].sel, rows[i].data, i % 3);
      case (rows[i].sel)
        SEL_COMMAND: ec = rows[i].data;
        SEL_DATA: ed = rows[i].data;
        SEL_ADDR_LOW, SEL_ADDR_M1, SEL_ADDR_M2, SEL_ADDR_HI: ea[16*(rows[i].sel-1) +: 16] = rows[i].data;
        default: ;
      endcase
      check(creg, ec);
      check(areg, ea);
      check(dreg, ed);
      check(rdy, 1'b1);
      check(dir, DIR_INPUT);
      check({dout, oe}, 32'h0);
      check(64'(n_done), 64'(i + 1));
    end
    fork
      host.wr(SEL_COMMAND, 16'h0F0F, 6);
      begin
        repeat (6) @(posedge CORE_CLK);
        #1;
        check(rdy, 1'b0);
      end
    join
    check(creg, 16'h0F0F);
    check(64'(n_done), 64'd10);
    RESET_N <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check(rdy, READY_RESET);
    check({creg, dreg}, 32'h0);
    check(areg, 64'h0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
